//--- chan_if.sv
// per-channel bitstream and detector settings between front-end modules
`timescale 1ns/1ps
interface chan_if;
  logic       bit_valid;
  logic       bit_val;
  logic       det_en;
  logic       win_long;
  logic [4:0] thr;
  logic       over;
  logic [5:0] level;
  modport src (output bit_valid, output bit_val, output det_en, output win_long,
               output thr, input over, input level);
  modport det (input bit_valid, input bit_val, input det_en, input win_long,
               input thr, output over, output level);
endinterface

//--- host_model.sv
// host side sink for filtered samples, prompt or slow acceptance
`timescale 1ns/1ps
module host_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample,
  output logic             sample_ready,
  output logic [15:0]      last,
  output logic [15:0]      prev
);
  logic tog;
  // slow host accepts every other cycle, hold stalls it entirely
  assign sample_ready = !hold && (!slow || tog);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tog  <= 1'b0;
      last <= 16'h0000;
      prev <= 16'h0000;
    end else begin
      tog <= !tog;
      if (sample_valid && sample_ready) begin
        last <= sample;
        prev <= last;
      end
    end
  end
endmodule

//--- overload_det.sv
// sliding-window overload detector for one modulator bitstream
`timescale 1ns/1ps
module overload_det #(
  parameter int depth = rx_front_pkg::win_long
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  chan_if.det       ch
);
  initial begin
    if (depth != rx_front_pkg::win_long) $error("depth must be 64");
  end

  logic [depth-1:0] hist;
  logic signed [7:0] sum;
  logic              win_q;
  wire  leaving   = ch.win_long ? hist[depth-1] : hist[rx_front_pkg::win_short-1];
  // each bit weighs +-1/2: sum counts in halves doubled, average = sum/2
  wire  signed [7:0] delta = (ch.bit_val ? 8'sh01 : -8'sh01) - (leaving ? 8'sh01 : -8'sh01);
  wire  signed [7:0] avg   = sum >>> 1;
  wire  [7:0]        mag   = avg[7] ? 8'(-avg) : 8'(avg);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hist  <= '0;
      sum   <= -8'sh40;
      win_q <= 1'b0;
    end else if (!ch.det_en || (ch.win_long != win_q)) begin
      // a window change restarts the sum so it never leaves its range
      hist  <= '0;
      sum   <= ch.win_long ? -8'sh40 : -8'sh20;
      win_q <= ch.win_long;
    end else if (ch.bit_valid) begin
      hist <= {hist[depth-2:0], ch.bit_val};
      sum  <= sum + delta;
    end
  end

  assign ch.over  = ch.det_en && (mag > {3'h0, ch.thr});
  assign ch.level = mag[5:0];

  sum_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sum <= 8'sh40 && sum >= -8'sh40) else $error("window sum out of range");
  det_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !ch.det_en |-> !ch.over) else $error("overflow while disabled");
endmodule

//--- rx_front_pkg.sv
// constants shared by the receive front-end design
package rx_front_pkg;
  // register offsets on the serial control port
  localparam logic [7:0]  input_routing_addr  = 8'h1d;
  localparam logic [7:0]  overload_cfg_addr   = 8'h1e;
  localparam logic [7:0]  bias_low_addr       = 8'hcb;
  localparam logic [7:0]  bias_high_addr      = 8'hcc;
  // reset values and bias high write mask
  localparam logic [15:0] input_routing_reset = 16'h0000;
  localparam logic [15:0] overload_cfg_reset  = 16'h0000;
  localparam logic [15:0] bias_low_reset      = 16'h9333;
  localparam logic [15:0] bias_high_reset     = 16'h004f;
  localparam logic [15:0] bias_high_mask      = 16'h03ff;
  // input routing fields
  localparam int cal_select_bit = 15;
  localparam int en_b_bit       = 14;
  localparam int inv_b_bit      = 13;
  localparam int gain_b_lsb     = 8;
  localparam int en_a_bit       = 6;
  localparam int inv_a_bit      = 5;
  localparam int gain_a_lsb     = 0;
  // overload fields
  localparam int win_b_bit      = 14;
  localparam int ovf_en_b_bit   = 13;
  localparam int thr_b_lsb      = 8;
  localparam int win_a_bit      = 6;
  localparam int ovf_en_a_bit   = 5;
  localparam int thr_a_lsb      = 0;
  // gain codes
  localparam logic [4:0] gain_mute_code = 5'h10;
  localparam logic [4:0] gain_min_code  = 5'h14;
  localparam logic [4:0] gain_max_code  = 5'h0c;
  localparam logic [4:0] gain_zero_code = 5'h00;
  // window lengths
  localparam int win_short = 32;
  localparam int win_long  = 64;
  // sinc limits
  localparam int sinc_min_stages = 3;
  localparam int sinc_max_stages = 6;
  localparam int sinc_max_len    = 64;
  localparam int sinc_acc_w      = 37;
  localparam int sel_out_w       = 20;
  localparam int sample_w        = 16;

  // analogue gain setting carried to the amplifier
  typedef struct packed {
    logic       mute;
    logic [4:0] db;
  } gain_t;

  // gain code to amplifier setting; out of range codes saturate
  function automatic gain_t decode_gain(input logic [4:0] code, input logic cal);
    gain_t g;
    g.mute = 1'b0;
    g.db   = code;
    if (cal) begin
      g.db = gain_zero_code;
    end else if (code == gain_mute_code) begin
      g.mute = 1'b1;
    end else if (code[4] && code < gain_min_code) begin
      g.db = gain_min_code;
    end else if (!code[4] && code > gain_max_code) begin
      g.db = gain_max_code;
    end
    return g;
  endfunction
endpackage

//--- rx_input_overflow_sinc_front.sv
// receive front-end: routing, gain, overload detect and sinc front
`timescale 1ns/1ps
module rx_input_overflow_sinc_front (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // serial control port write strobe
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  // overflow status read and clear
  input  wire logic        status_clr,
  // sample clock enable and modulator bits
  input  wire logic        modulator_sample_clock,
  input  wire logic        mod_bit_a,
  input  wire logic        mod_bit_b,
  input  wire logic        aux_diff_en_a,
  input  wire logic        aux_diff_en_b,
  // sinc settings shared by both channels
  input  wire logic [1:0]  sinc_stages_code,
  input  wire logic [5:0]  sinc_len_code,
  input  wire logic [4:0]  sel_shift,
  input  wire logic        sample_ready_a,
  input  wire logic        sample_ready_b,
  output logic             sample_valid_a,
  output logic [15:0]      sample_a,
  output logic             sample_valid_b,
  output logic [15:0]      sample_b,
  output logic             ovf_a,
  output logic             ovf_b,
  output logic             inphase_calibration_pin_to_a,
  output logic             quadrature_calibration_pin_to_b,
  output logic             midrail_reference_to_neg,
  output logic             gain_pwr_a,
  output logic             gain_pwr_b,
  output logic             mod_pwr_a,
  output logic             mod_pwr_b,
  output logic [5:0]       gain_set_a,
  output logic [5:0]       gain_set_b,
  output logic [15:0]      adc_bias_low_reg,
  output logic [15:0]      adc_bias_high_reg,
  output logic             stall_a,
  output logic             stall_b
);
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [15:0] input_routing;
  logic [15:0] overload_detect_reg;

  wire wr_route = reg_wr && (reg_addr == rx_front_pkg::input_routing_addr);
  wire wr_ovl   = reg_wr && (reg_addr == rx_front_pkg::overload_cfg_addr);
  wire wr_bl    = reg_wr && (reg_addr == rx_front_pkg::bias_low_addr);
  wire wr_bh    = reg_wr && (reg_addr == rx_front_pkg::bias_high_addr);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_routing       <= rx_front_pkg::input_routing_reset;
      overload_detect_reg <= rx_front_pkg::overload_cfg_reset;
      adc_bias_low_reg    <= rx_front_pkg::bias_low_reset;
      adc_bias_high_reg   <= rx_front_pkg::bias_high_reset;
    end else begin
      if (wr_route) input_routing <= reg_wdata & 16'hff7f;
      if (wr_ovl)   overload_detect_reg <= reg_wdata & 16'h7f7f;
      if (wr_bl)    adc_bias_low_reg <= reg_wdata;
      if (wr_bh)    adc_bias_high_reg <= reg_wdata & rx_front_pkg::bias_high_mask;
    end
  end

  // ------------------------------------------------------------
  // routing, power and gain
  // ------------------------------------------------------------
  wire cal = input_routing[rx_front_pkg::cal_select_bit];
  wire en_a = input_routing[rx_front_pkg::en_a_bit];
  wire en_b = input_routing[rx_front_pkg::en_b_bit];
  wire rx_front_pkg::gain_t next_gain_a =
    rx_front_pkg::decode_gain(input_routing[rx_front_pkg::gain_a_lsb +: 5], cal);
  wire rx_front_pkg::gain_t next_gain_b =
    rx_front_pkg::decode_gain(input_routing[rx_front_pkg::gain_b_lsb +: 5], cal);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      inphase_calibration_pin_to_a    <= 1'b0;
      quadrature_calibration_pin_to_b <= 1'b0;
      midrail_reference_to_neg        <= 1'b0;
      gain_pwr_a <= 1'b0;
      gain_pwr_b <= 1'b0;
      mod_pwr_a  <= 1'b0;
      mod_pwr_b  <= 1'b0;
      gain_set_a <= '0;
      gain_set_b <= '0;
    end else begin
      inphase_calibration_pin_to_a    <= cal;
      quadrature_calibration_pin_to_b <= cal;
      midrail_reference_to_neg        <= cal;
      gain_pwr_a <= en_a || aux_diff_en_a;
      gain_pwr_b <= en_b || aux_diff_en_b;
      mod_pwr_a  <= en_a;
      mod_pwr_b  <= en_b;
      gain_set_a <= next_gain_a;
      gain_set_b <= next_gain_b;
    end
  end

  // ------------------------------------------------------------
  // bitstream conditioning and overload detectors
  // ------------------------------------------------------------
  wire bit_a = mod_bit_a ^ input_routing[rx_front_pkg::inv_a_bit];
  wire bit_b = mod_bit_b ^ input_routing[rx_front_pkg::inv_b_bit];
  wire step_a = modulator_sample_clock && en_a;
  wire step_b = modulator_sample_clock && en_b;

  chan_if ch_a ();
  chan_if ch_b ();
  assign ch_a.bit_valid = step_a;
  assign ch_a.bit_val   = bit_a;
  assign ch_a.det_en    = overload_detect_reg[rx_front_pkg::ovf_en_a_bit];
  assign ch_a.win_long  = overload_detect_reg[rx_front_pkg::win_a_bit];
  assign ch_a.thr       = overload_detect_reg[rx_front_pkg::thr_a_lsb +: 5];
  assign ch_b.bit_valid = step_b;
  assign ch_b.bit_val   = bit_b;
  assign ch_b.det_en    = overload_detect_reg[rx_front_pkg::ovf_en_b_bit];
  assign ch_b.win_long  = overload_detect_reg[rx_front_pkg::win_b_bit];
  assign ch_b.thr       = overload_detect_reg[rx_front_pkg::thr_b_lsb +: 5];

  overload_det #(.depth(rx_front_pkg::win_long)) u_det_a (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ch       (ch_a.det)
  );
  overload_det #(.depth(rx_front_pkg::win_long)) u_det_b (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ch       (ch_b.det)
  );

  // sticky status: a new overflow wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ovf_a <= 1'b0;
      ovf_b <= 1'b0;
    end else begin
      ovf_a <= ch_a.over || (ovf_a && !status_clr);
      ovf_b <= ch_b.over || (ovf_b && !status_clr);
    end
  end

  // ------------------------------------------------------------
  // sinc front of each channel filter
  // ------------------------------------------------------------
  logic       v_a;
  logic       v_b;
  logic [15:0] d_a;
  logic [15:0] d_b;
  logic       rdy_a;
  logic       rdy_b;
  wire        take_a = !sample_valid_a || sample_ready_a;
  wire        take_b = !sample_valid_b || sample_ready_b;

  sinc_stage #(.acc_w(rx_front_pkg::sinc_acc_w)) u_sinc_a (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .in_valid    (step_a),
    .in_bit      (bit_a),
    .stages_code (sinc_stages_code),
    .len_code    (sinc_len_code),
    .shift       (sel_shift),
    .out_ready   (take_a),
    .out_valid   (v_a),
    .out_data    (d_a),
    .in_ready    (rdy_a)
  );
  sinc_stage #(.acc_w(rx_front_pkg::sinc_acc_w)) u_sinc_b (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .in_valid    (step_b),
    .in_bit      (bit_b),
    .stages_code (sinc_stages_code),
    .len_code    (sinc_len_code),
    .shift       (sel_shift),
    .out_ready   (take_b),
    .out_valid   (v_b),
    .out_data    (d_b),
    .in_ready    (rdy_b)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sample_valid_a <= 1'b0;
      sample_valid_b <= 1'b0;
      sample_a <= '0;
      sample_b <= '0;
      stall_a  <= 1'b0;
      stall_b  <= 1'b0;
    end else begin
      if (take_a) begin
        sample_valid_a <= v_a;
        sample_a       <= d_a;
      end
      if (take_b) begin
        sample_valid_b <= v_b;
        sample_b       <= d_b;
      end
      stall_a <= !rdy_a;
      stall_b <= !rdy_b;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  cal_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(cal) |=> inphase_calibration_pin_to_a && midrail_reference_to_neg) else $error("cal route late");
  cal_gain_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cal |=> gain_set_a == 6'h00 && gain_set_b == 6'h00) else $error("cal gain not 0 dB");
  chan_pwr_a: assert property (@(posedge core_clk) disable iff (!rstn)
    en_a |=> gain_pwr_a && mod_pwr_a) else $error("channel A not powered");
  aux_pwr_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (aux_diff_en_b && !en_b) |=> gain_pwr_b && !mod_pwr_b) else $error("aux power wrong");
  mute_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (!cal && input_routing[12:8] == 5'h10) |=> gain_set_b[5]) else $error("mute lost");
  ovf_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ch_a.over |=> ovf_a) else $error("overflow not flagged");
  ovf_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (ovf_b && !status_clr) |=> ovf_b) else $error("overflow flag dropped");
  sample_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (sample_valid_a && !sample_ready_a) |=> sample_valid_a && $stable(sample_a))
    else $error("sample lost under stall");
endmodule

//--- sinc_stage.sv
// cascaded sinc decimating section with two-entry output buffer
`timescale 1ns/1ps
module sinc_stage #(
  parameter int acc_w = rx_front_pkg::sinc_acc_w
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        in_valid,
  input  wire logic        in_bit,
  input  wire logic [1:0]  stages_code,
  input  wire logic [5:0]  len_code,
  input  wire logic [4:0]  shift,
  input  wire logic        out_ready,
  output logic             out_valid,
  output logic [15:0]      out_data,
  output logic             in_ready
);
  initial begin
    if (acc_w != rx_front_pkg::sinc_acc_w) $error("accumulator must be 37 bits");
  end
  localparam int ns = rx_front_pkg::sinc_max_stages;

  logic signed [acc_w-1:0] integ [ns];
  logic signed [acc_w-1:0] comb_d [ns];
  logic [5:0]              phase;
  logic signed [acc_w-1:0] buf_d [2];
  logic [1:0]              cnt;
  logic                    wr_ptr;
  logic                    rd_ptr;

  wire [2:0] nstage = 3'(stages_code) + 3'(rx_front_pkg::sinc_min_stages);
  wire [6:0] length = (len_code == 6'h00) ? 7'd64 : {1'b0, len_code};
  wire       dump   = in_valid && (7'(phase) + 7'd1 == length);
  assign in_ready = (cnt != 2'd2);

  // comb chain evaluated on the decimated sample
  logic signed [acc_w-1:0] comb_o [ns+1];
  always_comb begin
    comb_o[0] = integ[ns-1];
    for (int i = 0; i < ns; i++) begin
      comb_o[i+1] = (i < 6 - int'(nstage)) ? comb_o[i] : comb_o[i] - comb_d[i];
    end
  end
  // unused leading integrators are bypassed so the chain has nstage sections
  wire signed [acc_w-1:0] in_w = in_bit ? acc_w'(1) : -acc_w'(1);
  // input of each integrator: the new bit for the first, the one before for the rest
  logic signed [acc_w-1:0] integ_in [ns];
  always_comb begin
    integ_in[0] = in_w;
    for (int i = 1; i < ns; i++) begin
      integ_in[i] = integ[i-1];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < ns; i++) begin
        integ[i]  <= '0;
        comb_d[i] <= '0;
      end
      phase <= '0;
    end else if (in_valid && in_ready) begin
      for (int i = 0; i < ns; i++) begin
        if (i < 6 - int'(nstage)) integ[i] <= integ_in[i];
        else integ[i] <= integ[i] + integ_in[i];
      end
      phase <= dump ? 6'h00 : phase + 6'h01;
      if (dump) begin
        for (int i = 0; i < ns; i++) comb_d[i] <= comb_o[i];
      end
    end
  end

  wire push = dump && in_ready;
  wire pop  = out_valid && out_ready;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0; wr_ptr <= 1'b0; rd_ptr <= 1'b0;
      buf_d[0] <= '0; buf_d[1] <= '0;
    end else begin
      if (push) begin
        buf_d[wr_ptr] <= comb_o[ns];
        wr_ptr <= ~wr_ptr;
      end
      if (pop) rd_ptr <= ~rd_ptr;
      cnt <= cnt + 2'(push) - 2'(pop);
    end
  end
  // 20-bit slice then top 16 bits as signed sample
  wire signed [acc_w-1:0] head = buf_d[rd_ptr] >>> shift;
  wire [19:0]             slice = head[19:0];
  assign out_valid = (cnt != 2'd0);
  assign out_data  = slice[19:4];

  fifo_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cnt <= 2'd2) else $error("buffer overfilled");
  full_stall_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (cnt == 2'd2 && !out_ready) |=> $stable(cnt)) else $error("full buffer changed");
endmodule

//--- testbench.sv
// self-checking bench for the receive front-end
`timescale 1ns/1ps
module testbench;
  logic        core_clk, rstn, reg_wr, status_clr, msc, bit_a, bit_b, aux_a, aux_b, hold;
  logic        rdy_a, rdy_b, sv_a, sv_b, ovf_a, ovf_b, cal_a, cal_b, cal_n;
  logic        gp_a, gp_b, mp_a, mp_b, stall_a, stall_b;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, smp_a, smp_b, bias_lo, bias_hi, held;
  logic [15:0] last_a, prev_a, last_b, prev_b;
  logic [1:0]  stg;
  logic [5:0]  len, gs_a, gs_b;
  logic [4:0]  shift;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [4:0]  codes [6] = '{5'h14, 5'h0c, 5'h1f, 5'h00, 5'h10, 5'h11};
  logic [5:0]  gexp  [6] = '{6'h14, 6'h0c, 6'h1f, 6'h00, 6'h30, 6'h14};

  rx_input_overflow_sinc_front dut_u (
    .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .status_clr(status_clr), .modulator_sample_clock(msc),
    .mod_bit_a(bit_a), .mod_bit_b(bit_b), .aux_diff_en_a(aux_a), .aux_diff_en_b(aux_b),
    .sinc_stages_code(stg), .sinc_len_code(len), .sel_shift(shift),
    .sample_ready_a(rdy_a), .sample_ready_b(rdy_b), .sample_valid_a(sv_a),
    .sample_a(smp_a), .sample_valid_b(sv_b), .sample_b(smp_b), .ovf_a(ovf_a),
    .ovf_b(ovf_b), .inphase_calibration_pin_to_a(cal_a),
    .quadrature_calibration_pin_to_b(cal_b), .midrail_reference_to_neg(cal_n),
    .gain_pwr_a(gp_a), .gain_pwr_b(gp_b), .mod_pwr_a(mp_a), .mod_pwr_b(mp_b),
    .gain_set_a(gs_a), .gain_set_b(gs_b), .adc_bias_low_reg(bias_lo),
    .adc_bias_high_reg(bias_hi), .stall_a(stall_a), .stall_b(stall_b));
  host_model host_a (.core_clk(core_clk), .rstn(rstn), .hold(hold), .slow(1'b0),
    .sample_valid(sv_a), .sample(smp_a), .sample_ready(rdy_a), .last(last_a), .prev(prev_a));
  host_model host_b (.core_clk(core_clk), .rstn(rstn), .hold(hold), .slow(1'b1),
    .sample_valid(sv_b), .sample(smp_b), .sample_ready(rdy_b), .last(last_b), .prev(prev_b));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bits(input int n, input logic a, input logic b, input logic alt);
    for (int i = 0; i < n; i++) begin
      msc = 1'b1;
      bit_a = alt ? i[0] : a;
      bit_b = alt ? i[0] : b;
      tick();
      msc = 1'b0;
      tick();
    end
  endtask
  task automatic print_verdict();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rstn, reg_wr, status_clr, msc, bit_a, bit_b, aux_a, aux_b, hold} = '0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    stg = 2'h0;
    len = 6'h04;
    shift = 5'h00;
    repeat (8) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk(bias_lo, 16'h9333);
    chk(bias_hi, 16'h004f);
    chk({4'h0, gs_a, gs_b}, 16'h0000);
    wr(8'hcb, 16'h6bbb);
    wr(8'hcc, 16'h00ee);
    wr(8'h55, 16'h1234);
    chk(bias_lo, 16'h6bbb);
    chk(bias_hi, 16'h00ee);
    wr(8'hcc, 16'hffff);
    chk(bias_hi, 16'h03ff);
    $display("test bias done");
    for (int i = 0; i < 6; i++) begin
      wr(8'h1d, {3'b000, codes[i], 3'b000, codes[i]});
      chk({10'h000, gs_a}, {10'h000, gexp[i]});
      chk({10'h000, gs_b}, {10'h000, gexp[i]});
    end
    wr(8'h1d, 16'h8c0c);
    chk({13'h0000, cal_a, cal_b, cal_n}, 16'h0007);
    chk({4'h0, gs_a, gs_b}, 16'h0000);
    wr(8'h1d, 16'h4040);
    chk({12'h000, gp_a, gp_b, mp_a, mp_b}, 16'h000f);
    wr(8'h1d, 16'h0000);
    aux_a = 1'b1;
    aux_b = 1'b1;
    tick(2);
    chk({12'h000, gp_a, gp_b, mp_a, mp_b}, 16'h000c);
    aux_a = 1'b0;
    aux_b = 1'b0;
    $display("test routing done");
    // short window at threshold 16 never flags; channel b detector off
    wr(8'h1d, 16'h4040);
    wr(8'h1e, 16'h0030);
    bits(40, 1'b1, 1'b1, 1'b0);
    chk({14'h0000, ovf_a, ovf_b}, 16'h0000);
    wr(8'h1d, 16'h6040);
    wr(8'h1e, 16'h7f7f);
    bits(64, 1'b0, 1'b0, 1'b1);
    status_clr = 1'b1;
    tick();
    status_clr = 1'b0;
    tick();
    bits(8, 1'b0, 1'b0, 1'b1);
    chk({14'h0000, ovf_a, ovf_b}, 16'h0000);
    bits(64, 1'b1, 1'b1, 1'b0);
    chk({14'h0000, ovf_a, ovf_b}, 16'h0003);
    $display("test overload done");
    hold = 1'b1;
    bits(40, 1'b1, 1'b1, 1'b0);
    chk({12'h000, stall_a, sv_a, stall_b, sv_b}, 16'h000f);
    held = smp_a;
    bits(4, 1'b1, 1'b1, 1'b0);
    chk(smp_a, held);
    hold = 1'b0;
    bits(40, 1'b1, 1'b1, 1'b0);
    tick(20);
    chk(prev_a, last_a);
    chk({12'h000, sv_a, stall_a, sv_b, stall_b}, 16'h0000);
    chk(16'(last_a == last_b), 16'h0000);
    $display("test samples done");
    print_verdict();
  end
endmodule
